// >>> hw/dpgc_map.svh
// constants for the power-down and gear-down control block
`ifndef DPGC_MAP_SVH
`define DPGC_MAP_SVH

// clock period of mclk in ns
`define DPGC_CLK_NS          5
// command-path disable delay after clock-enable falls, in clocks
`define DPGC_CPDED_CYC       4'h4
// multiplexed exit window after self-refresh exit, in ns
`define DPGC_MUX_EXIT_NS     30
// window length in clocks, rounded down (a longest time)
`define DPGC_MUX_EXIT_CYC    ((`DPGC_MUX_EXIT_NS) / (`DPGC_CLK_NS))
// mode register select, timer width and timer zero value
`define DPGC_MR_THREE        3'h3
`define DPGC_TIMER_W         4
`define DPGC_TIMER_ZERO      4'h0

`endif

// >>> hw/dpgc_pkg.sv
// types shared by the power-down and gear-down control block
package dpgc_pkg;

    // decoded command bus as registered on a rising clock edge
    typedef struct packed {
        logic       deselect;
        logic       no_operation_cmd;
        logic       refresh;
        logic       mode_reg_write_cmd;
        logic [2:0] mr_sel;
        logic       addr_a3;
    } dpgc_cmd_t;

    // mode register bits that steer the block
    typedef struct packed {
        logic term_buf_disable;
        logic nominal_termination;
        logic park_termination;
        logic parity_en;
        logic cal_en;
    } dpgc_cfg_t;

    // pin and termination state shown to the rest of the device
    typedef struct packed {
        logic ca_rx_en;
        logic io_buf_en;
        logic term_rx_en;
        logic nom_term_on;
        logic park_term_on;
    } dpgc_buf_t;

    // gray-coded power state along idle, entry, power-down, self refresh, exit
    typedef enum logic [2:0] {
        DPGC_IDLE = 3'h0,
        DPGC_PDE  = 3'h1,
        DPGC_PD   = 3'h3,
        DPGC_SR   = 3'h2,
        DPGC_SRX  = 3'h6
    } dpgc_state_t;

    typedef enum logic [1:0] {
        DPGC_HALF  = 2'h0,
        DPGC_SYNC  = 2'h1,
        DPGC_QUART = 2'h3
    } dpgc_gear_t;

endpackage

// >>> hw/dpgc_timer.sv
// loadable down counter with a done flag
`include "dpgc_map.svh"

module dpgc_timer (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      load,
    input  wire logic [`DPGC_TIMER_W-1:0]  value,
    output logic                           done
);
    logic [`DPGC_TIMER_W-1:0] cnt_reg;
    logic [`DPGC_TIMER_W-1:0] cnt_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        if (load)
        begin
            cnt_next = value;
        end
        else if (cnt_reg != `DPGC_TIMER_ZERO)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_reg <= `DPGC_TIMER_ZERO;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == `DPGC_TIMER_ZERO) && !load;
endmodule

// >>> hw/dpgc_ctl.sv
// power-down, self-refresh exit and gear-down control inside the memory device
`include "dpgc_map.svh"

module dpgc_ctl (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               cke,
    input  wire logic               dev_reset_n,
    input  dpgc_pkg::dpgc_cmd_t     cmd,
    input  dpgc_pkg::dpgc_cfg_t     cfg,
    input  wire logic               bank_open,
    input  wire logic               ops_busy,
    output dpgc_pkg::dpgc_buf_t     bufs,
    output logic                    pd_active,
    output logic                    pd_precharge,
    output logic                    selfref,
    output logic                    quarter_rate,
    output logic                    cmd_taken,
    output logic                    gear_uncertain
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dpgc_pkg::dpgc_state_t state_reg;
    dpgc_pkg::dpgc_state_t state_next;
    dpgc_pkg::dpgc_gear_t  gear_reg;
    dpgc_pkg::dpgc_gear_t  gear_next;
    dpgc_pkg::dpgc_buf_t   bufs_reg;
    dpgc_pkg::dpgc_buf_t   bufs_next;
    logic                  pd_active_reg;
    logic                  pd_active_next;
    logic                  pd_precharge_reg;
    logic                  pd_precharge_next;
    logic                  cmd_taken_reg;
    logic                  cmd_taken_next;
    logic                  uncertain_reg;
    logic                  uncertain_next;
    logic                  gear_window_reg;
    logic                  gear_window_next;
    logic                  sync_odd_reg;
    logic                  sync_odd_next;
    logic                  phase_reg;
    logic                  phase_next;
    logic                  nop_exit_ok_reg;
    logic                  nop_exit_ok_next;
    logic                  tmr_load;
    logic [`DPGC_TIMER_W-1:0] tmr_value;
    logic                  tmr_done;
    logic                  rx_on;
    logic                  sample;
    logic                  any_cmd;

    dpgc_timer u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .load  (tmr_load),
        .value (tmr_value),
        .done  (tmr_done)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next        = state_reg;
        gear_next         = gear_reg;
        pd_active_next    = pd_active_reg;
        pd_precharge_next = pd_precharge_reg;
        uncertain_next    = uncertain_reg;
        gear_window_next  = gear_window_reg;
        sync_odd_next     = ~sync_odd_reg;
        phase_next        = ~phase_reg;
        nop_exit_ok_next  = nop_exit_ok_reg;
        cmd_taken_next    = 1'b0;
        tmr_load          = 1'b0;
        tmr_value         = `DPGC_CPDED_CYC;
        // receivers are live outside full power-down and self refresh
        rx_on   = (state_reg == dpgc_pkg::DPGC_IDLE) ||
                  (state_reg == dpgc_pkg::DPGC_PDE)  ||
                  (state_reg == dpgc_pkg::DPGC_SRX);
        // in quarter rate only the aligned edge samples control lines
        sample  = rx_on && cke && ((gear_reg != dpgc_pkg::DPGC_QUART) || phase_reg);
        any_cmd = !cmd.deselect;

        unique case (state_reg)
            dpgc_pkg::DPGC_IDLE:
            begin
                if (!cke && cmd.refresh)
                begin
                    state_next       = dpgc_pkg::DPGC_SR;
                    gear_next        = dpgc_pkg::DPGC_HALF;
                    nop_exit_ok_next = !cfg.parity_en && !cfg.cal_en;
                end
                else if (!cke && cmd.deselect)
                begin
                    state_next = dpgc_pkg::DPGC_PDE;
                    tmr_load   = 1'b1;
                end
                else if (sample && any_cmd)
                begin
                    cmd_taken_next = 1'b1;
                end
            end
            dpgc_pkg::DPGC_PDE:
            begin
                if (cke && cmd.deselect)
                begin
                    state_next = dpgc_pkg::DPGC_IDLE;
                end
                else if (tmr_done)
                begin
                    state_next = dpgc_pkg::DPGC_PD;
                end
            end
            dpgc_pkg::DPGC_PD:
            begin
                // only clock-enable is watched; the command bus is off
                if (cke)
                begin
                    state_next = dpgc_pkg::DPGC_IDLE;
                end
            end
            dpgc_pkg::DPGC_SR:
            begin
                if (cke && (cmd.deselect || (cmd.no_operation_cmd && nop_exit_ok_reg)))
                begin
                    state_next       = dpgc_pkg::DPGC_SRX;
                    gear_window_next = 1'b1;
                    tmr_load         = 1'b1;
                    tmr_value        = `DPGC_TIMER_W'(`DPGC_MUX_EXIT_CYC);
                end
            end
            dpgc_pkg::DPGC_SRX:
            begin
                // only no-op or deselect is expected inside the exit window
                if (tmr_done)
                begin
                    state_next = dpgc_pkg::DPGC_IDLE;
                end
            end
            default:
            begin
                state_next = dpgc_pkg::DPGC_IDLE;
            end
        endcase

        // power-down flavour settles once in-flight work drains
        if (state_next == dpgc_pkg::DPGC_PDE || state_next == dpgc_pkg::DPGC_PD)
        begin
            pd_active_next = 1'b1;
            if (!ops_busy)
            begin
                pd_precharge_next = !bank_open;
            end
        end
        else
        begin
            pd_active_next    = 1'b0;
            pd_precharge_next = 1'b0;
        end

        // gear-down sequence
        if (sample && cmd.mode_reg_write_cmd && cmd.mr_sel == `DPGC_MR_THREE)
        begin
            if (cmd.addr_a3 && gear_window_reg && gear_reg == dpgc_pkg::DPGC_HALF)
            begin
                gear_next     = dpgc_pkg::DPGC_SYNC;
                sync_odd_next = 1'b1;
            end
            else if (!cmd.addr_a3 && gear_reg == dpgc_pkg::DPGC_QUART)
            begin
                uncertain_next = 1'b1;
            end
        end
        else if (gear_reg == dpgc_pkg::DPGC_SYNC && rx_on && cmd.no_operation_cmd)
        begin
            if (!sync_odd_reg)
            begin
                gear_next  = dpgc_pkg::DPGC_QUART;
                phase_next = 1'b0;
            end
            else
            begin
                gear_next = dpgc_pkg::DPGC_HALF;
            end
        end
        // any command other than refresh or a mode register write closes the window
        if (sample && any_cmd && !cmd.refresh && !cmd.mode_reg_write_cmd)
        begin
            gear_window_next = 1'b0;
        end
        if (state_next == dpgc_pkg::DPGC_SR)
        begin
            uncertain_next = 1'b0;
        end

        // reset pin pulls the device out of any state
        if (!dev_reset_n)
        begin
            state_next        = dpgc_pkg::DPGC_IDLE;
            gear_next         = dpgc_pkg::DPGC_HALF;
            gear_window_next  = 1'b1;
            pd_active_next    = 1'b0;
            pd_precharge_next = 1'b0;
            uncertain_next    = 1'b0;
            cmd_taken_next    = 1'b0;
        end

        // buffer and termination state, after the reset override
        bufs_next.ca_rx_en     = (state_next == dpgc_pkg::DPGC_IDLE) ||
                                 (state_next == dpgc_pkg::DPGC_PDE)  ||
                                 (state_next == dpgc_pkg::DPGC_SRX);
        bufs_next.io_buf_en    = (state_next == dpgc_pkg::DPGC_IDLE) ||
                                 (state_next == dpgc_pkg::DPGC_SRX);
        bufs_next.term_rx_en   = bufs_next.io_buf_en || !cfg.term_buf_disable;
        bufs_next.nom_term_on  = cfg.nominal_termination &&
                                 bufs_next.term_rx_en;
        bufs_next.park_term_on = cfg.park_termination;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg        <= dpgc_pkg::DPGC_IDLE;
            gear_reg         <= dpgc_pkg::DPGC_HALF;
            bufs_reg         <= '0;
            pd_active_reg    <= 1'b0;
            pd_precharge_reg <= 1'b0;
            cmd_taken_reg    <= 1'b0;
            uncertain_reg    <= 1'b0;
            gear_window_reg  <= 1'b1;
            sync_odd_reg     <= 1'b0;
            phase_reg        <= 1'b0;
            nop_exit_ok_reg  <= 1'b0;
        end
        else
        begin
            state_reg        <= state_next;
            gear_reg         <= gear_next;
            bufs_reg         <= bufs_next;
            pd_active_reg    <= pd_active_next;
            pd_precharge_reg <= pd_precharge_next;
            cmd_taken_reg    <= cmd_taken_next;
            uncertain_reg    <= uncertain_next;
            gear_window_reg  <= gear_window_next;
            sync_odd_reg     <= sync_odd_next;
            phase_reg        <= phase_next;
            nop_exit_ok_reg  <= nop_exit_ok_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bufs           = bufs_reg;
    assign pd_active      = pd_active_reg;
    assign pd_precharge   = pd_precharge_reg;
    assign selfref        = (state_reg == dpgc_pkg::DPGC_SR);
    assign quarter_rate   = (gear_reg == dpgc_pkg::DPGC_QUART);
    assign cmd_taken      = cmd_taken_reg;
    assign gear_uncertain = uncertain_reg;
endmodule

// >>> tb/dpgc_ctl_sva.sv
// checker for the power-down and gear-down control block
module dpgc_ctl_sva (
    input wire logic           mclk,
    input wire logic           rst,
    input wire logic           cke,
    input wire logic           dev_reset_n,
    input dpgc_pkg::dpgc_cmd_t cmd,
    input dpgc_pkg::dpgc_cfg_t cfg,
    input wire logic           bank_open,
    input wire logic           ops_busy,
    input dpgc_pkg::dpgc_buf_t bufs,
    input wire logic           pd_active,
    input wire logic           pd_precharge,
    input wire logic           selfref,
    input wire logic           quarter_rate,
    input wire logic           cmd_taken,
    input wire logic           gear_uncertain
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pd_entry: assert property (!pd_active && !selfref && !quarter_rate && !cke
        && cmd.deselect && dev_reset_n |=> pd_active)
        else $error("power-down not entered");
    a_pd_exit: assert property (pd_active && cke && cmd.deselect && dev_reset_n
        && !quarter_rate |=> !pd_active)
        else $error("power-down not left");
    a_buf_off: assert property (pd_active |-> !bufs.io_buf_en)
        else $error("io buffers on in power-down");
    a_rx_delay: assert property ($rose(pd_active) |-> bufs.ca_rx_en [*5]
        ##1 (!bufs.ca_rx_en || !pd_active))
        else $error("command receiver off time wrong");
    a_pd_flavour: assert property (pd_active && $past(pd_active) && !ops_busy
        && $stable(bank_open) |-> pd_precharge == !bank_open)
        else $error("power-down flavour wrong");
    a_term_rx: assert property (pd_active && !bufs.ca_rx_en && $stable(cfg) |->
        bufs.term_rx_en != cfg.term_buf_disable
        && bufs.park_term_on == cfg.park_termination
        && !(cfg.term_buf_disable && bufs.nom_term_on))
        else $error("termination state wrong");
    a_reset_pd: assert property (!dev_reset_n |=> !pd_active && !selfref
        && !quarter_rate)
        else $error("device reset not honoured");
    a_sr_half: assert property (selfref ##1 selfref |-> !quarter_rate)
        else $error("quarter rate in self refresh");
    a_sync_nop: assert property ($rose(quarter_rate) |-> $past(cmd.no_operation_cmd))
        else $error("quarter rate without sync pulse");
    a_cmd_ignore: assert property (selfref [*3] |-> !cmd_taken)
        else $error("command taken in self refresh");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_pd: cover property ($rose(pd_active));
    c_gear: cover property ($rose(quarter_rate));
    c_sr: cover property ($rose(selfref));
endmodule

// >>> tb/dpgc_mc_model.sv
// memory controller model driving clock-enable and the command bus
`include "dpgc_map.svh"

module dpgc_mc_model (
    input  wire logic          cke_req,
    input  wire logic [1:0]    op,
    input  wire logic          a3,
    input  wire logic          ops_busy,
    output logic               cke,
    output dpgc_pkg::dpgc_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock-enable held high while operations are in flight
    assign cke = cke_req | ops_busy;

    // op: 0 deselect, 1 no-op, 2 refresh, 3 gear mode write
    always_comb
    begin
        cmd = '0;
        cmd.mr_sel = `DPGC_MR_THREE;
        cmd.addr_a3 = a3;
        if (op == 2'h2)
            cmd.refresh = 1'b1;
        else if (!cke_req || op == 2'h0)
            cmd.deselect = 1'b1;
        else if (op == 2'h1)
            cmd.no_operation_cmd = 1'b1;
        else
            cmd.mode_reg_write_cmd = 1'b1;
    end
endmodule

// >>> tb/dpgc_ctl_test.sv
// self-checking bench for the power-down and gear-down control block
`include "dpgc_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

module dpgc_ctl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk, rst, dev_reset_n, cke_req, a3, bank_open, ops_busy, cke;
    logic                pd_active, pd_precharge, selfref, quarter_rate;
    logic                cmd_taken, gear_uncertain;
    logic [1:0]          op;
    dpgc_pkg::dpgc_cmd_t cmd;
    dpgc_pkg::dpgc_cfg_t cfg;
    dpgc_pkg::dpgc_buf_t bufs;
    int                  num_errors, n_tests, cycles, n;

    dpgc_mc_model mc (.cke_req(cke_req), .op(op), .a3(a3), .ops_busy(ops_busy), .cke(cke),
        .cmd(cmd));
    dpgc_ctl dut (.mclk(mclk), .rst(rst), .cke(cke), .dev_reset_n(dev_reset_n), .cmd(cmd),
        .cfg(cfg), .bank_open(bank_open), .ops_busy(ops_busy), .bufs(bufs),
        .pd_active(pd_active), .pd_precharge(pd_precharge), .selfref(selfref),
        .quarter_rate(quarter_rate), .cmd_taken(cmd_taken), .gear_uncertain(gear_uncertain));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic drive(input logic [1:0] o, input logic c, input int k);
        repeat (k)
        begin
            @(posedge mclk);
            op <= o;
            cke_req <= c;
        end
        // return between edges so outputs are settled when looked at
        @(negedge mclk);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        op <= 2'h0;
        cke_req <= 1'b1;
        dev_reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
    endtask

    task automatic wait_pd(input logic v);
        n = 0;
        do @(negedge mclk); while (pd_active !== v && n++ < 8);
    endtask

    // gear write, then the sync no-op gap cycles after it
    task automatic gear(input int gap);
        a3 <= 1'b1;
        drive(2'h3, 1'b1, 1);
        drive(2'h0, 1'b1, gap - 1);
        drive(2'h1, 1'b1, 1);
        drive(2'h0, 1'b1, 1);
        repeat (3) @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_gear();
        do_reset();
        repeat (2) @(negedge mclk);
        `CHK(bufs.ca_rx_en, 1'b1)
        `CHK(quarter_rate, 1'b0)
        gear(2);
        `CHK(quarter_rate, 1'b1)
        a3 <= 1'b0;
        drive(2'h3, 1'b1, 2);
        drive(2'h0, 1'b1, 3);
        `CHK(quarter_rate, 1'b1)
        `CHK(gear_uncertain, 1'b1)
        drive(2'h2, 1'b0, 2);
        drive(2'h0, 1'b0, 4);
        `CHK(selfref, 1'b1)
        `CHK(quarter_rate, 1'b0)
        `CHK(gear_uncertain, 1'b0)
        drive(2'h0, 1'b1, 10);
        `CHK(selfref, 1'b0)
        gear(3);
        `CHK(quarter_rate, 1'b0)
        drive(2'h1, 1'b1, 1);
        drive(2'h0, 1'b1, 1);
        n = 0;
        repeat (4)
        begin
            n += (cmd_taken === 1'b1);
            @(negedge mclk);
        end
        `CHK(n, 1)
    endtask

    task automatic t_pd(input int i);
        do_reset();
        bank_open <= i[0];
        cfg.park_termination <= i[0];
        cfg.term_buf_disable <= i[1];
        drive(2'h0, 1'b1, 2);
        drive(2'h0, 1'b0, 1);
        wait_pd(1'b1);
        `CHK(pd_active, 1'b1)
        `CHK(pd_precharge, ~bank_open)
        `CHK(bufs.io_buf_en, 1'b0)
        n = 0;
        while (bufs.ca_rx_en === 1'b1 && n < 20)
        begin
            n++;
            @(negedge mclk);
        end
        `CHK(n, `DPGC_CPDED_CYC + 1)
        `CHK(bufs.term_rx_en, ~cfg.term_buf_disable)
        `CHK(bufs.park_term_on, cfg.park_termination)
        drive(2'h0, 1'b0, 4);
        drive(2'h0, 1'b1, 1);
        wait_pd(1'b0);
        `CHK(pd_active, 1'b0)
        `CHK(bufs.ca_rx_en, 1'b1)
    endtask

    task automatic t_dev_reset();
        do_reset();
        drive(2'h0, 1'b0, 1);
        wait_pd(1'b1);
        @(posedge mclk);
        dev_reset_n <= 1'b0;
        wait_pd(1'b0);
        `CHK(pd_active, 1'b0)
        `CHK(selfref, 1'b0)
        @(posedge mclk);
        dev_reset_n <= 1'b1;
        cke_req <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        rst = 1'b1;
        dev_reset_n = 1'b1;
        cke_req = 1'b1;
        op = 2'h0;
        a3 = 1'b0;
        bank_open = 1'b0;
        ops_busy = 1'b0;
        cfg = '0;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        t_gear();
        for (int i = 0; i < 4; i++)
            t_pd(i);
        t_dev_reset();
        results();
    end
endmodule

bind dpgc_ctl dpgc_ctl_sva u_sva (.mclk(mclk), .rst(rst), .cke(cke),
    .dev_reset_n(dev_reset_n), .cmd(cmd), .cfg(cfg), .bank_open(bank_open),
    .ops_busy(ops_busy), .bufs(bufs), .pd_active(pd_active), .pd_precharge(pd_precharge),
    .selfref(selfref), .quarter_rate(quarter_rate), .cmd_taken(cmd_taken),
    .gear_uncertain(gear_uncertain));
